// >>> verilog/mpni_port.sv
// mpni_port: mii port, nibble transmit and receive toward an ethernet phy
// assumes the phy runs both link clocks whenever the port is out of reset
`timescale 1ns/1ns
`default_nettype none
// Summary of operation
// - Transmit nibbles driven on transmit clock
// - Frame enable rises with first preamble nibble
// - Frame enable held until last nibble sent
// - Receive nibbles sampled on receive clock
// - Carrier rises asynchronously; device synchronises it
module mpni_port
(
    input  wire logic                        ref_clk,            // system clock
    input  wire logic                        rst,                // sync reset
    input  wire logic                        tx_in_valid,        // byte offered
    output logic                             tx_in_ready,        // byte accepted
    input  wire logic [mpni_pkg::BYTE_W-1:0] tx_in_data,         // frame byte
    input  wire logic                        tx_in_last,         // last byte
    output logic                             rx_out_valid,       // word ready
    input  wire logic                        rx_out_ready,       // word taken
    output logic      [mpni_pkg::BYTE_W-1:0] rx_out_data,        // byte/status
    output logic                             rx_out_last,        // end marker
    output logic                             carrier_sense,      // synced crs
    output logic                             collision,          // synced col
    output logic                             tx_collision_seen,  // sticky
    input  wire logic                        tx_collision_clr,   // clears it
    input  wire logic                        phy_tx_clock_in,    // tx clock
    output logic      [mpni_pkg::NIB_W-1:0]  tx_nibble_bus,      // tx data
    output logic                             tx_frame_enable,    // tx enable
    input  wire logic                        phy_rx_clock_in,    // rx clock
    input  wire logic [mpni_pkg::NIB_W-1:0]  rx_nibble_bus,      // rx data
    input  wire logic                        rx_valid_flag,      // rx valid
    input  wire logic                        collision_flag,     // col pin
    input  wire logic                        carrier_sense_flag  // crs pin
);
    import mpni_pkg::*;

    // reset carried into each link domain
    logic rst_t1, tx_rst, rst_r1, rx_rst;

    always_ff @(posedge phy_tx_clock_in)
    begin
        rst_t1 <= rst;
        tx_rst <= rst_t1;
    end

    always_ff @(posedge phy_rx_clock_in)
    begin
        rst_r1 <= rst;
        rx_rst <= rst_r1;
    end

    // ---------------- transmit, link side ----------------
    logic                   txf_valid, txf_ready;
    logic [WORD_W-1:0]      txf_data;
    mpni_tx_state_t         tx_state_reg, tx_state_next;
    logic [3:0]             tx_cnt_reg, tx_cnt_next;
    logic                   tx_hi_reg, tx_hi_next;
    logic                   tx_en_reg, tx_en_next;
    logic [NIB_W-1:0]       tx_nib_reg, tx_nib_next;
    logic                   col_t1, col_t2;
    logic                   col_hit_reg, col_hit_next;
    logic                   col_tog_reg, col_tog_next;

    mpni_fifo #(.W(WORD_W), .D(FIFO_DEPTH)) tx_fifo
    (
        .wr_clk   (ref_clk),
        .wr_rst   (rst),
        .wr_valid (tx_in_valid),
        .wr_ready (tx_in_ready),
        .wr_data  ({tx_in_last, tx_in_data}),
        .rd_clk   (phy_tx_clock_in),
        .rd_rst   (tx_rst),
        .rd_valid (txf_valid),
        .rd_ready (txf_ready),
        .rd_data  (txf_data)
    );

    always_comb
    begin
        tx_state_next = tx_state_reg;
        tx_cnt_next   = tx_cnt_reg;
        tx_hi_next    = tx_hi_reg;
        tx_en_next    = tx_en_reg;
        tx_nib_next   = tx_nib_reg;
        txf_ready     = 1'b0;
        case (tx_state_reg)
            TX_IDLE:
            begin
                tx_en_next  = 1'b0;
                tx_nib_next = IDLE_NIB;
                // one idle cycle with enable low between frames
                if (txf_valid && !tx_en_reg)
                begin
                    tx_state_next = TX_PRE;
                    tx_en_next    = 1'b1;
                    tx_nib_next   = PRE_NIB;
                    tx_cnt_next   = CNT_ZERO;
                end
            end
            TX_PRE:
            begin
                tx_cnt_next = tx_cnt_reg + CNT_ONE;
                tx_nib_next = PRE_NIB;
                if (tx_cnt_reg == PRE_LAST)
                begin
                    tx_nib_next   = SFD_NIB;
                    tx_state_next = TX_DATA;
                    tx_hi_next    = 1'b0;
                end
            end
            TX_DATA:
            begin
                if (!tx_hi_reg && !txf_valid)
                begin
                    // underrun: abort frame rather than send garbage
                    tx_state_next = TX_IDLE;
                    tx_en_next    = 1'b0;
                    tx_nib_next   = IDLE_NIB;
                end
                else if (!tx_hi_reg)
                begin
                    tx_nib_next = txf_data[HI_LSB-1:0];
                    tx_hi_next  = 1'b1;
                end
                else
                begin
                    tx_nib_next = txf_data[BYTE_W-1:HI_LSB];
                    tx_hi_next  = 1'b0;
                    txf_ready   = 1'b1;
                    if (txf_data[LAST_BIT])
                    begin
                        tx_state_next = TX_IDLE;
                    end
                end
            end
            default:
            begin
                tx_state_next = TX_IDLE;
                tx_en_next    = 1'b0;
            end
        endcase
        col_hit_next = tx_en_reg && col_t2;
        col_tog_next = col_tog_reg ^ (col_hit_next && !col_hit_reg);
    end

    always_ff @(posedge phy_tx_clock_in)
    begin
        col_t1 <= collision_flag;
        col_t2 <= col_t1;
        if (tx_rst)
        begin
            tx_state_reg <= TX_IDLE;
            tx_cnt_reg   <= CNT_ZERO;
            tx_hi_reg    <= 1'b0;
            tx_en_reg    <= 1'b0;
            tx_nib_reg   <= IDLE_NIB;
            col_hit_reg  <= 1'b0;
            col_tog_reg  <= 1'b0;
        end
        else
        begin
            tx_state_reg <= tx_state_next;
            tx_cnt_reg   <= tx_cnt_next;
            tx_hi_reg    <= tx_hi_next;
            tx_en_reg    <= tx_en_next;
            tx_nib_reg   <= tx_nib_next;
            col_hit_reg  <= col_hit_next;
            col_tog_reg  <= col_tog_next;
        end
    end

    assign tx_frame_enable = tx_en_reg;
    assign tx_nibble_bus   = tx_nib_reg;

    // ---------------- receive, link side ----------------
    logic [NIB_W-1:0]  rxd_q, rx_lo_reg, rx_lo_next;
    logic              rxv_q, rxv_prev;
    logic              rx_hi_reg, rx_hi_next;
    logic              rx_ovf_reg, rx_ovf_next;
    logic              rxw_valid_reg, rxw_valid_next, rxw_ready;
    logic [WORD_W-1:0] rxw_data_reg, rxw_data_next, rxf_data;

    always_comb
    begin
        rx_lo_next     = rx_lo_reg;
        rx_hi_next     = rx_hi_reg;
        rx_ovf_next    = rx_ovf_reg;
        rxw_valid_next = 1'b0;
        rxw_data_next  = rxw_data_reg;
        if (rxv_q)
        begin
            if (!rx_hi_reg)
            begin
                rx_lo_next = rxd_q;
                rx_hi_next = 1'b1;
            end
            else
            begin
                rx_hi_next    = 1'b0;
                rxw_data_next = {1'b0, rxd_q, rx_lo_reg};
                if (rxw_ready)
                begin
                    rxw_valid_next = 1'b1;
                end
                else
                begin
                    rx_ovf_next = 1'b1;
                end
            end
        end
        else if (rxv_prev)
        begin
            // frame end marker: {overflow, odd nibble}
            rxw_valid_next = 1'b1;
            rxw_data_next  = {1'b1, MARK_PAD, rx_ovf_reg, rx_hi_reg};
            rx_hi_next     = 1'b0;
            rx_ovf_next    = 1'b0;
        end
    end

    always_ff @(posedge phy_rx_clock_in)
    begin
        rxd_q    <= rx_nibble_bus;
        rxv_q    <= rx_valid_flag;
        rxv_prev <= rxv_q;
        if (rx_rst)
        begin
            rx_lo_reg     <= IDLE_NIB;
            rx_hi_reg     <= 1'b0;
            rx_ovf_reg    <= 1'b0;
            rxw_valid_reg <= 1'b0;
            rxw_data_reg  <= '0;
        end
        else
        begin
            rx_lo_reg     <= rx_lo_next;
            rx_hi_reg     <= rx_hi_next;
            rx_ovf_reg    <= rx_ovf_next;
            rxw_valid_reg <= rxw_valid_next;
            rxw_data_reg  <= rxw_data_next;
        end
    end

    mpni_fifo #(.W(WORD_W), .D(FIFO_DEPTH)) rx_fifo
    (
        .wr_clk   (phy_rx_clock_in),
        .wr_rst   (rx_rst),
        .wr_valid (rxw_valid_reg),
        .wr_ready (rxw_ready),
        .wr_data  (rxw_data_reg),
        .rd_clk   (ref_clk),
        .rd_rst   (rst),
        .rd_valid (rx_out_valid),
        .rd_ready (rx_out_ready),
        .rd_data  (rxf_data)
    );

    assign rx_out_data = rxf_data[BYTE_W-1:0];
    assign rx_out_last = rxf_data[LAST_BIT];

    // ---------------- system side status ----------------
    logic crs_s1, crs_s2, colr_s1, colr_s2;
    logic tog_s1, tog_s2, tog_s3;
    logic seen_reg, seen_next, col_event;

    always_comb
    begin
        col_event = tog_s2 ^ tog_s3;
        seen_next = col_event || (seen_reg && !tx_collision_clr);
    end

    always_ff @(posedge ref_clk)
    begin
        crs_s1  <= carrier_sense_flag;
        crs_s2  <= crs_s1;
        colr_s1 <= collision_flag;
        colr_s2 <= colr_s1;
        tog_s1  <= col_tog_reg;
        tog_s2  <= tog_s1;
        if (rst)
        begin
            tog_s3   <= 1'b0;
            seen_reg <= 1'b0;
        end
        else
        begin
            tog_s3   <= tog_s2;
            seen_reg <= seen_next;
        end
    end

    assign carrier_sense     = crs_s2;
    assign collision         = colr_s2;
    assign tx_collision_seen = seen_reg;

    // ---------------- checks ----------------
    chk_txen_reset_low: assert property (@(posedge phy_tx_clock_in)
        tx_rst |=> !tx_frame_enable)
        else $error("frame enable not low after reset");

    chk_pre_first_nib: assert property (@(posedge phy_tx_clock_in)
        disable iff (tx_rst)
        $rose(tx_frame_enable) |-> tx_nibble_bus == PRE_NIB)
        else $error("enable rose without preamble nibble");

    chk_pre_sfd_pos: assert property (@(posedge phy_tx_clock_in)
        disable iff (tx_rst)
        $rose(tx_frame_enable) |-> tx_frame_enable[*8] ##8 (tx_nibble_bus == SFD_NIB))
        else $error("start delimiter not at nibble sixteen");

    chk_txen_in_frame: assert property (@(posedge phy_tx_clock_in)
        disable iff (tx_rst)
        tx_state_reg != TX_IDLE |-> tx_frame_enable)
        else $error("enable dropped inside frame");

    chk_tx_idle_bus: assert property (@(posedge phy_tx_clock_in)
        disable iff (tx_rst)
        !tx_frame_enable |-> tx_nibble_bus == IDLE_NIB)
        else $error("nibble bus not idle outside frame");

    chk_rx_end_mark: assert property (@(posedge phy_rx_clock_in)
        disable iff (rx_rst)
        $fell(rxv_q) |=> rxw_valid_reg && rxw_data_reg[LAST_BIT])
        else $error("no end marker after valid dropped");

    chk_rx_no_push: assert property (@(posedge phy_rx_clock_in)
        disable iff (rx_rst)
        !rxv_q && !rxv_prev |=> !rxw_valid_reg)
        else $error("word pushed outside a frame");

    chk_col_sticky: assert property (@(posedge ref_clk)
        disable iff (rst)
        col_event |=> tx_collision_seen)
        else $error("collision event lost");

    chk_col_clear: assert property (@(posedge ref_clk)
        disable iff (rst)
        tx_collision_clr && !col_event |=> !tx_collision_seen)
        else $error("collision flag not cleared");

endmodule
`default_nettype wire

// >>> verilog/mpni_pkg.sv
// mpni_pkg: constants and types shared by the mii nibble port and its fifo
// assumes nothing beyond a systemverilog compiler
package mpni_pkg;

    localparam int          FIFO_DEPTH = 8;
    localparam int          BYTE_W     = 8;
    localparam int          WORD_W     = 9;    // {last, byte}
    localparam int          NIB_W      = 4;
    localparam int          LAST_BIT   = 8;
    localparam int          HI_LSB     = 4;

    localparam logic [3:0]  PRE_NIB    = 4'h5;
    localparam logic [3:0]  SFD_NIB    = 4'hD;
    localparam logic [3:0]  IDLE_NIB   = 4'h0;
    localparam logic [3:0]  PRE_LAST   = 4'hE; // index of last 0x5 nibble
    localparam logic [3:0]  CNT_ZERO   = 4'h0;
    localparam logic [3:0]  CNT_ONE    = 4'h1;
    localparam logic [5:0]  MARK_PAD   = 6'h00;

    typedef enum logic [1:0]
    {
        TX_IDLE = 2'b00,
        TX_PRE  = 2'b01,
        TX_DATA = 2'b10
    } mpni_tx_state_t;

endpackage

// >>> verilog/mpni_fifo.sv
// mpni_fifo: dual clock fifo, gray coded pointers, valid/ready both sides
// assumes each reset is synchronous to its own clock; depth a power of two
`timescale 1ns/1ns
`default_nettype none
module mpni_fifo
#(
    parameter int W = 9,
    parameter int D = 8
)
(
    input  wire logic         wr_clk,   // filling side clock
    input  wire logic         wr_rst,   // filling side reset
    input  wire logic         wr_valid, // word offered
    output logic              wr_ready, // room for a word
    input  wire logic [W-1:0] wr_data,  // word in
    input  wire logic         rd_clk,   // draining side clock
    input  wire logic         rd_rst,   // draining side reset
    output logic              rd_valid, // head word present
    input  wire logic         rd_ready, // head word taken
    output logic      [W-1:0] rd_data   // head word
);
    import mpni_pkg::*;

    localparam int AW = $clog2(D);

    function automatic logic [AW:0] to_gray(input logic [AW:0] b);
        to_gray = b ^ (b >> 1);
    endfunction

    logic [W-1:0] mem [D];
    logic [AW:0]  wbin_reg, wbin_next, wgray_reg, rq1_reg, rq2_reg;
    logic [AW:0]  rbin_reg, rbin_next, rgray_reg, wq1_reg, wq2_reg;
    logic         wr_fire, rd_fire;

    always_comb
    begin
        wr_ready  = (wgray_reg != {~rq2_reg[AW:AW-1], rq2_reg[AW-2:0]});
        wr_fire   = wr_valid && wr_ready;
        wbin_next = wr_fire ? wbin_reg + 1'b1 : wbin_reg;
        rd_valid  = (rgray_reg != wq2_reg);
        rd_fire   = rd_valid && rd_ready;
        rbin_next = rd_fire ? rbin_reg + 1'b1 : rbin_reg;
        rd_data   = mem[rbin_reg[AW-1:0]];
    end

    always_ff @(posedge wr_clk)
    begin
        if (wr_fire)
        begin
            mem[wbin_reg[AW-1:0]] <= wr_data;
        end
        rq1_reg <= rgray_reg;
        rq2_reg <= rq1_reg;
        if (wr_rst)
        begin
            wbin_reg  <= '0;
            wgray_reg <= '0;
        end
        else
        begin
            wbin_reg  <= wbin_next;
            wgray_reg <= to_gray(wbin_next);
        end
    end

    always_ff @(posedge rd_clk)
    begin
        wq1_reg <= wgray_reg;
        wq2_reg <= wq1_reg;
        if (rd_rst)
        begin
            rbin_reg  <= '0;
            rgray_reg <= '0;
        end
        else
        begin
            rbin_reg  <= rbin_next;
            rgray_reg <= to_gray(rbin_next);
        end
    end

endmodule
`default_nettype wire

// >>> verif/mpni_phy_model.sv
// mpni_phy_model: behavioural ethernet phy facing the mii nibble port
// assumes the bench reaches its tasks and counters hierarchically
`timescale 1ns/1ns
`default_nettype none
module mpni_phy_model
(
    output logic            phy_tx_clock_in,    // tx link clock
    output logic            phy_rx_clock_in,    // rx link clock
    input  wire logic [3:0] tx_nibble_bus,      // tx data
    input  wire logic       tx_frame_enable,    // tx enable
    output logic      [3:0] rx_nibble_bus,      // rx data
    output logic            rx_valid_flag,      // rx valid
    output logic            collision_flag,     // col pin
    output logic            carrier_sense_flag  // crs pin
);
    logic [3:0] tx_nibs[$];
    int         tx_frames;
    int         idle_bad;
    logic       en_d;
    logic       rx_busy;
    logic       want;

    initial
    begin
        {phy_tx_clock_in, phy_rx_clock_in, rx_valid_flag, collision_flag} = 4'h0;
        {carrier_sense_flag, rx_busy, en_d} = 3'h0;
        rx_nibble_bus = 4'h0;
        tx_frames = 0;
        idle_bad = 0;
        #3;
        fork
            forever
            begin
                #7 phy_tx_clock_in = 1'b1;
                #8 phy_tx_clock_in = 1'b0;
            end
            forever
            begin
                #4 phy_rx_clock_in = 1'b1;
                #7 phy_rx_clock_in = 1'b0;
                #4;
            end
        join
    end

    always @(posedge phy_tx_clock_in)
    begin
        if (tx_frame_enable === 1'b1)
            tx_nibs.push_back(tx_nibble_bus);
        else if (tx_nibble_bus !== 4'h0)
            idle_bad++;
        if (en_d === 1'b1 && tx_frame_enable !== 1'b1)
            tx_frames++;
        en_d = tx_frame_enable;
    end

    // idle data toggles so no stale nibble is mistaken for data
    always @(posedge phy_rx_clock_in)
        if (!rx_busy)
            rx_nibble_bus <= #2 ~rx_nibble_bus;

    assign want = rx_busy | tx_frame_enable | collision_flag;
    always @(posedge want)
        #3 carrier_sense_flag = 1'b1;
    always @(posedge phy_rx_clock_in)
        if (want !== 1'b1)
            carrier_sense_flag <= 1'b0;

    task automatic send_rx(input logic [7:0] b[$], input bit odd, input logic [3:0] tail);
        logic [3:0] n[$];
        n = {};
        foreach (b[i])
        begin
            n.push_back(b[i][3:0]);
            n.push_back(b[i][7:4]);
        end
        if (odd)
            n.push_back(tail);
        rx_busy = 1'b1;
        @(posedge phy_rx_clock_in);
        foreach (n[i])
        begin
            #2;
            rx_valid_flag = 1'b1;
            rx_nibble_bus = n[i];
            @(posedge phy_rx_clock_in);
        end
        #2;
        rx_valid_flag = 1'b0;
        rx_nibble_bus = ~rx_nibble_bus;
        rx_busy = 1'b0;
    endtask

    task automatic pulse_col(input int len);
        @(posedge phy_tx_clock_in iff tx_frame_enable === 1'b1);
        repeat (4) @(posedge phy_tx_clock_in);
        #2 collision_flag = 1'b1;
        repeat (len) @(posedge phy_rx_clock_in);
        #2 collision_flag = 1'b0;
    endtask
endmodule
`default_nettype wire

// >>> verif/test_mii_port_nibble_interface.sv
// test_mii_port_nibble_interface: self-checking bench for mpni_port
// assumes mpni_phy_model supplies both link clocks and the phy pins
`timescale 1ns/1ns
`default_nettype none
`define CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin n_errors++; \
    $display("[FAIL] %0t got %h exp %h", $time, got, exp); end end
module test_mii_port_nibble_interface;
    import mpni_pkg::*;
    logic       ref_clk;
    logic       rst;
    logic       tx_in_valid;
    logic       tx_in_ready;
    logic [7:0] tx_in_data;
    logic       tx_in_last;
    logic       rx_out_valid;
    logic       rx_out_ready;
    logic [7:0] rx_out_data;
    logic       rx_out_last;
    logic       carrier_sense;
    logic       collision;
    logic       tx_collision_seen;
    logic       tx_collision_clr;
    logic       phy_tx_clock_in;
    logic [3:0] tx_nibble_bus;
    logic       tx_frame_enable;
    logic       phy_rx_clock_in;
    logic [3:0] rx_nibble_bus;
    logic       rx_valid_flag;
    logic       collision_flag;
    logic       carrier_sense_flag;
    int         n_errors = 0;
    int         cmp_count = 0;
    int         cycles = 0;

    mpni_port i_dut (.ref_clk, .rst, .tx_in_valid, .tx_in_ready, .tx_in_data, .tx_in_last,
        .rx_out_valid, .rx_out_ready, .rx_out_data, .rx_out_last, .carrier_sense, .collision,
        .tx_collision_seen, .tx_collision_clr, .phy_tx_clock_in, .tx_nibble_bus,
        .tx_frame_enable, .phy_rx_clock_in, .rx_nibble_bus, .rx_valid_flag, .collision_flag,
        .carrier_sense_flag);

    mpni_phy_model i_phy (.phy_tx_clock_in, .phy_rx_clock_in, .tx_nibble_bus,
        .tx_frame_enable, .rx_nibble_bus, .rx_valid_flag, .collision_flag,
        .carrier_sense_flag);

    initial
    begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end

    task automatic end_of_test();
        if (n_errors == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            n_errors++;
            $display("[FAIL] %0t run hung", $time);
            end_of_test();
        end
    end

    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #2;
    endtask

    task automatic pop_word(input logic lst, input logic [7:0] d);
        int k;
        k = 0;
        while (rx_out_valid !== 1'b1 && k < 400)
        begin
            cyc(1);
            k++;
        end
        `CHK(rx_out_last, lst)
        `CHK(rx_out_data, d)
        rx_out_ready = 1'b1;
        cyc(1);
        rx_out_ready = 1'b0;
        cyc(1);
    endtask

    task automatic t_reset();
        `CHK(tx_frame_enable, 1'b0)
        `CHK(tx_nibble_bus, 4'h0)
        `CHK(tx_in_ready, 1'b1)
        `CHK(rx_out_valid, 1'b0)
        `CHK(tx_collision_seen, 1'b0)
    endtask

    task automatic t_tx(input int n, input bit col, input bit abort);
        int f;
        int k;
        logic [7:0] b;
        logic [3:0] e;
        i_phy.tx_nibs = {};
        f = i_phy.tx_frames;
        k = 0;
        fork
            if (col)
                i_phy.pulse_col(8);
            if (col)
            begin
                @(posedge collision_flag);
                cyc(2);
                `CHK(collision, 1'b1)
            end
        join_none
        for (int i = 0; i < n; i++)
        begin
            while (tx_in_ready !== 1'b1)
                cyc(1);
            tx_in_valid = 1'b1;
            tx_in_data = 8'h3C + 8'h11 * i[7:0];
            tx_in_last = (i == n - 1) && !abort;
            cyc(1);
        end
        tx_in_valid = 1'b0;
        tx_in_last = 1'b0;
        while (i_phy.tx_frames == f && k < 400)
        begin
            cyc(1);
            k++;
        end
        `CHK(i_phy.tx_nibs.size(), 16 + 2 * n)
        foreach (i_phy.tx_nibs[j])
        begin
            b = 8'h3C + 8'h11 * 8'((j - 16) / 2);
            e = (j < 15) ? PRE_NIB : (j == 15) ? SFD_NIB : j[0] ? b[7:4] : b[3:0];
            `CHK(i_phy.tx_nibs[j], e)
        end
        `CHK(i_phy.idle_bad, 0)
        cyc(4);
        `CHK(tx_collision_seen, col)
        `CHK(collision, 1'b0)
        tx_collision_clr = 1'b1;
        cyc(1);
        tx_collision_clr = 1'b0;
        cyc(1);
        `CHK(tx_collision_seen, 1'b0)
    endtask

    task automatic t_rx();
        logic [7:0] q[$];
        q = {8'hA5, 8'h3C, 8'h0F, 8'hF0};
        fork
            i_phy.send_rx(q, 1'b1, 4'h7);
            begin
                cyc(2);
                `CHK(carrier_sense, 1'b1)
            end
        join
        cyc(6);
        `CHK(carrier_sense, 1'b0)
        foreach (q[i])
            pop_word(1'b0, q[i]);
        pop_word(1'b1, 8'h01);
    endtask

    task automatic t_ovf();
        logic [7:0] q[$];
        q = {};
        for (int i = 0; i < 9; i++)
            q.push_back(8'h80 + 8'(i));
        i_phy.send_rx(q, 1'b0, 4'h0);
        cyc(6);
        for (int i = 0; i < 8; i++)
            pop_word(1'b0, q[i]);
        cyc(10);
        `CHK(rx_out_valid, 1'b0)
    endtask

    initial
    begin
        rst = 1'b1;
        tx_in_valid = 1'b0;
        tx_in_data = 8'h00;
        tx_in_last = 1'b0;
        rx_out_ready = 1'b0;
        tx_collision_clr = 1'b0;
        repeat (8) @(posedge ref_clk);
        #2 rst = 1'b0;
        cyc(4);
        i_phy.idle_bad = 0;
        t_reset();
        t_tx(6, 1'b0, 1'b0);
        t_tx(1, 1'b1, 1'b0);
        t_tx(2, 1'b0, 1'b1);
        t_rx();
        t_ovf();
        end_of_test();
    end
endmodule
`default_nettype wire
